// *** verilog/pgpio_pkg.sv ***
// Purpose: Shared constants for the two-port GPIO block with bus sharing.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes:   Printed offsets are register indices; byte address is four times the index.
package pgpio_pkg;
    // ----------------------------------------
    // Register indices and geometry
    // ----------------------------------------
    localparam int          PW           = 8;
    localparam logic [3:0]  IDX_P0_DATA  = 4'h0;
    localparam logic [3:0]  IDX_P1_DATA  = 4'h1;
    localparam logic [3:0]  IDX_P0_DIR   = 4'h2;
    localparam logic [3:0]  IDX_P1_DIR   = 4'h4;
    localparam logic [3:0]  IDX_P1_FUNC  = 4'h5;
    localparam logic [3:0]  IDX_BUS_STAT = 4'h8;
    localparam int          ADDR_W       = 6;
    localparam int          IDX_LSB      = 2;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    // Port 1 pin roles, coded as {function, direction}.
    localparam logic [1:0]  ROLE_IN      = 2'h0;
    localparam logic [1:0]  ROLE_OUT     = 2'h1;
    localparam logic [1:0]  ROLE_ADHI    = 2'h2;
    localparam logic [1:0]  ROLE_AMID    = 2'h3;
endpackage

// *** verilog/pgpio_sync.sv ***
// Purpose: Two-flop synchroniser for a vector of pin levels.
// Assumes: Inputs are asynchronous to aclk.
// Notes:   The first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none
module pgpio_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pgpio_sync_s;
    pgpio_sync_s st_q;
    pgpio_sync_s st_d;

    always_comb begin
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.s2;
endmodule // pgpio_sync
`default_nettype wire

// *** verilog/pgpio_top.sv ***
// Purpose: Ports 0 and 1 GPIO with sharing of pins by the external memory bus.
// Assumes: AXI4-Lite slave, one clock, synchronous active-low reset.
// Notes:   Pins are split into input, output and output enable.
// Behaviour
// - Port 0 has eight pins each settable as input or output, and reset makes all inputs.
// - A port 0 direction bit of 0 makes the pin an input and 1 makes it an output.
// - External access makes port 0 the low address/data byte and clears its direction bits.
// - The port 0 output latch is cleared to zero by reset and drives the pins only while port 0 is not on the bus.
// - With external program memory port 0 is always the low address/data byte.
// - Port 1 has eight pins each set by its own direction bit and function bit.
// - Reset clears port 1 latch, direction and function registers and makes its pins inputs.
// - Port 1 can serve as the high multiplexed byte or as address bits 15 to 8.
// - With external program memory port 1 is always the high address/data byte.
// - On bus release, address/data pins float while general port pins keep their state.
`timescale 1ns/1ps
`default_nettype none
module pgpio_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Memory controller side
    input  wire logic        ext_prog_mem,
    input  wire logic        ext_access,
    input  wire logic        bus_release_ack_n,
    input  wire logic [7:0]  low_muxed_addr_data_out,
    input  wire logic [7:0]  high_muxed_addr_data_out,
    input  wire logic [7:0]  mid_address_out,
    input  wire logic        addr_data_drive,
    output logic [7:0]       low_muxed_addr_data_in,
    output logic [7:0]       high_muxed_addr_data_in,
    // Port 0 pins
    input  wire logic [7:0]  port0_pin_i,
    output logic [7:0]       port0_pin_o,
    output logic [7:0]       port0_pin_oe,
    // Port 1 pins
    input  wire logic [7:0]  port1_pin_i,
    output logic [7:0]       port1_pin_o,
    output logic [7:0]       port1_pin_oe
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]  p0_lat;
        logic [7:0]  p1_lat;
        logic [7:0]  p0_dir;
        logic [7:0]  p1_dir;
        logic [7:0]  p1_func;
        logic        bus_mode;
        logic        awr;
        logic        wr;
        logic        bv;
        logic [1:0]  br;
        logic        arr;
        logic        rv;
        logic [31:0] rd;
        logic [1:0]  rr;
        logic [7:0]  p0o;
        logic [7:0]  p0e;
        logic [7:0]  p1o;
        logic [7:0]  p1e;
        logic [7:0]  lin;
        logic [7:0]  hin;
    } pgpio_s;
    pgpio_s q;
    pgpio_s d;

    logic [7:0] p0_sync;
    logic [7:0] p1_sync;
    logic [2:0] ctl_sync_a;
    logic [2:0] ctl_sync;

    // Pins and asynchronous strap/control levels pass two flops first.
    pgpio_sync #(.W(8)) u_s0 (
        .aclk(aclk), .aresetn(aresetn), .async_in(port0_pin_i), .sync_out(p0_sync));
    pgpio_sync #(.W(8)) u_s1 (
        .aclk(aclk), .aresetn(aresetn), .async_in(port1_pin_i), .sync_out(p1_sync));
    pgpio_sync #(.W(3)) u_sc (
        .aclk(aclk), .aresetn(aresetn), .async_in(ctl_sync_a), .sync_out(ctl_sync));
    assign ctl_sync_a = {ext_prog_mem, ext_access, bus_release_ack_n};

    function automatic logic [3:0] widx(input logic [5:0] a);
        return a[pgpio_pkg::ADDR_W-1:pgpio_pkg::IDX_LSB];
    endfunction

    function automatic logic [7:0] mix(input logic [7:0] dir, input logic [7:0] lat,
                                       input logic [7:0] pin);
        return (dir & lat) | (~dir & pin);
    endfunction

    logic       xpm;
    logic       xacc;
    logic       rel;
    logic       do_w;
    logic       do_r;
    logic [3:0] wi;
    logic [7:0] wb;
    logic [7:0] p0_rb;
    logic [7:0] p1_rb;
    logic [7:0] p1_out_dir;
    logic [7:0] adhi;
    logic [7:0] amid;
    logic       p0_bus;

    always_comb begin
        xpm  = ctl_sync[2];
        xacc = ctl_sync[1];
        rel  = !ctl_sync[0];
        d    = q;
        do_w = q.awr && q.wr && !q.bv;
        do_r = q.arr && !q.rv;
        wi   = widx(s_axi_awaddr);
        wb   = s_axi_wdata[7:0];
        // The address is used at the taking edge, so the master must hold it until ready.
        // ----------------------------------------
        // Bus slave: accept address and data in either order
        // ----------------------------------------
        if (s_axi_awvalid && !q.awr && !q.bv) begin
            d.awr = 1'b1;
        end
        if (s_axi_wvalid && !q.wr && !q.bv) begin
            d.wr = 1'b1;
        end
        if (q.bv && s_axi_bready) begin
            d.bv = 1'b0;
        end
        // ----------------------------------------
        // Port 0 bus takeover
        // ----------------------------------------
        // Bus mode is latched so that a short access still leaves port 0 on the bus.
        if (xacc) begin
            d.bus_mode = 1'b1;
            d.p0_dir   = pgpio_pkg::RST_BYTE;
        end
        if (do_w) begin
            d.awr = 1'b0;
            d.wr  = 1'b0;
            d.bv  = 1'b1;
            d.br  = pgpio_pkg::RESP_OKAY;
            if (s_axi_wstrb[0]) begin
                unique case (wi)
                    pgpio_pkg::IDX_P0_DATA: d.p0_lat = wb;
                    pgpio_pkg::IDX_P1_DATA: d.p1_lat = wb;
                    pgpio_pkg::IDX_P0_DIR: begin
                        // Hardware takeover wins over a software write in the same cycle.
                        if (!xacc) begin
                            d.p0_dir   = wb;
                            d.bus_mode = 1'b0;
                        end
                    end
                    pgpio_pkg::IDX_P1_DIR:  d.p1_dir  = wb;
                    pgpio_pkg::IDX_P1_FUNC: d.p1_func = wb;
                    default:                d.br = pgpio_pkg::RESP_SLVERR;
                endcase
            end
        end
        // ----------------------------------------
        // Pin drive
        // ----------------------------------------
        p0_bus = q.bus_mode || xpm;
        adhi   = q.p1_func & ~q.p1_dir;
        amid   = q.p1_func & q.p1_dir;
        p1_out_dir = ~q.p1_func & q.p1_dir;
        if (xpm) begin
            adhi       = 8'hff;
            amid       = 8'h00;
            p1_out_dir = 8'h00;
        end
        if (p0_bus) begin
            d.p0o = low_muxed_addr_data_out;
            d.p0e = (addr_data_drive && !rel) ? 8'hff : 8'h00;
        end else begin
            d.p0o = q.p0_lat;
            d.p0e = q.p0_dir;
        end
        d.p1o = (adhi & high_muxed_addr_data_out) | (amid & mid_address_out) |
                (p1_out_dir & q.p1_lat);
        d.p1e = p1_out_dir | (rel ? 8'h00 : ((addr_data_drive ? adhi : 8'h00) | amid));
        d.lin = p0_sync;
        d.hin = p1_sync;
        // ----------------------------------------
        // Read path
        // ----------------------------------------
        p0_rb = mix(p0_bus ? 8'h00 : q.p0_dir, q.p0_lat, p0_sync);
        p1_rb = mix(p1_out_dir, q.p1_lat, p1_sync);
        if (s_axi_arvalid && !q.arr && !q.rv) begin
            d.arr = 1'b1;
        end
        if (q.rv && s_axi_rready) begin
            d.rv = 1'b0;
        end
        if (do_r) begin
            d.arr = 1'b0;
            d.rv  = 1'b1;
            d.rr  = pgpio_pkg::RESP_OKAY;
            d.rd  = '0;
            unique case (widx(s_axi_araddr))
                pgpio_pkg::IDX_P0_DATA:  d.rd[7:0] = p0_rb;
                pgpio_pkg::IDX_P1_DATA:  d.rd[7:0] = p1_rb;
                pgpio_pkg::IDX_P0_DIR,
                pgpio_pkg::IDX_P1_DIR,
                pgpio_pkg::IDX_P1_FUNC:  d.rd = '0;
                pgpio_pkg::IDX_BUS_STAT: d.rd[2:0] = {rel, xpm, q.bus_mode};
                default:                 d.rr = pgpio_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign s_axi_awready = q.awr && q.wr && !q.bv;
    assign s_axi_wready  = q.awr && q.wr && !q.bv;
    assign s_axi_bvalid  = q.bv;
    assign s_axi_bresp   = q.br;
    assign s_axi_arready = q.arr && !q.rv;
    assign s_axi_rvalid  = q.rv;
    assign s_axi_rdata   = q.rd;
    assign s_axi_rresp   = q.rr;
    assign port0_pin_o   = q.p0o;
    assign port0_pin_oe  = q.p0e;
    assign port1_pin_o   = q.p1o;
    assign port1_pin_oe  = q.p1e;
    assign low_muxed_addr_data_in  = q.lin;
    assign high_muxed_addr_data_in = q.hin;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_p0_dir_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        ctl_sync[1] |=> (q.p0_dir == 8'h00)) else $error("port0 direction not cleared");
    chk_p0_reset_in: assert property (@(posedge aclk)
        !aresetn |=> (port0_pin_oe == 8'h00)) else $error("port0 not input after reset");
    chk_p1_reset: assert property (@(posedge aclk)
        !aresetn |=> (q.p1_lat == 8'h00 && q.p1_dir == 8'h00 && port1_pin_oe == 8'h00))
        else $error("port1 not cleared by reset");
    chk_p0_dir_oe: assert property (@(posedge aclk) disable iff (!aresetn)
        (!q.bus_mode && !ctl_sync[2]) |=> (port0_pin_oe == $past(q.p0_dir)))
        else $error("port0 enable does not follow direction");
    // Pin outputs are registered, so every pin check looks one clock past its cause.
    chk_xpm_p1: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctl_sync[2] && ctl_sync[0] && addr_data_drive) |=> (port1_pin_oe == 8'hff))
        else $error("port1 not bus in program memory mode");
    chk_release_z: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctl_sync[0] && (q.bus_mode || ctl_sync[2])) |=> (port0_pin_oe == 8'h00))
        else $error("port0 driven during bus release");
    chk_p1_out_role: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctl_sync[2]) |=> ((port1_pin_oe & ~$past(q.p1_func) & $past(q.p1_dir))
                            == (~$past(q.p1_func) & $past(q.p1_dir))))
        else $error("port1 general output not driven");
    chk_p1_release: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctl_sync[0] && !ctl_sync[2]) |=>
            (port1_pin_oe == (~$past(q.p1_func) & $past(q.p1_dir))))
        else $error("port1 bus pins driven during release");
    chk_p1_mid_out: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctl_sync[0] && !ctl_sync[2]) |=>
            ((port1_pin_o & $past(q.p1_func) & $past(q.p1_dir))
             == ($past(mid_address_out) & $past(q.p1_func) & $past(q.p1_dir))))
        else $error("port1 address-only pins wrong");
    chk_p1_adhi_out: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctl_sync[0] && !ctl_sync[2] && addr_data_drive) |=>
            ((port1_pin_oe & $past(q.p1_func)) == $past(q.p1_func)))
        else $error("port1 bus pins not driven");
    chk_xpm_p0: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctl_sync[2] && ctl_sync[0] && addr_data_drive) |=>
            (port0_pin_oe == 8'hff && port0_pin_o == $past(low_muxed_addr_data_out)))
        else $error("port0 not bus in program memory mode");
    chk_rd_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arready && s_axi_arvalid) |=> (s_axi_rvalid && s_axi_rdata[31:8] == 24'h0))
        else $error("read data missing or upper bits set");
    chk_bus_mode_set: assert property (@(posedge aclk) disable iff (!aresetn)
        ctl_sync[1] |=> q.bus_mode) else $error("port0 bus mode not entered");
    chk_wr_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_awready && s_axi_awvalid && s_axi_wvalid) |=> s_axi_bvalid)
        else $error("write response missing");
endmodule // pgpio_top
`default_nettype wire

// *** verification/pgpio_pin_model.sv ***
// Purpose: Pin-side model of the devices wired to one port.
// Assumes: Every bit the block leaves undriven is driven by a far device with ext_val.
// Notes:   No pulls exist, so a floating bit must never be left to the simulator.
`timescale 1ns/1ps
`default_nettype none
module pgpio_pin_model (
    // Block side
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe,
    // Far side
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_i
);
    // A driving block wins on its bits; the far device owns the rest.
    always_comb pin_i = (pin_o & pin_oe) | (ext_val & ~pin_oe);
endmodule // pgpio_pin_model
`default_nettype wire

// *** verification/ports_zero_one_gpio_bus_mux_tb_top.sv ***
// Purpose: Self-checking bench for the two-port GPIO block.
// Assumes: AXI4-Lite master with ready signals held high for responses.
// Notes:   Pin checks wait a fixed settle time covering the two-flop synchronisers.
`timescale 1ns/1ps
`default_nettype none
module ports_zero_one_gpio_bus_mux_tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
    logic        epm, eacc, rel_n, drv;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [7:0]  lo_o, hi_o, mid_o, lo_i, hi_i, p0i, p0o, p0oe, p1i, p1o, p1oe, ext0, ext1;
    logic [7:0]  rnd, d, f, l;
    int          err_count, checks;
    logic [1:0]  wq[$];
    logic [33:0] rq[$];
    logic [33:0] rnote;

    pgpio_top uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .ext_prog_mem(epm), .ext_access(eacc), .bus_release_ack_n(rel_n),
        .low_muxed_addr_data_out(lo_o), .high_muxed_addr_data_out(hi_o),
        .mid_address_out(mid_o), .addr_data_drive(drv),
        .low_muxed_addr_data_in(lo_i), .high_muxed_addr_data_in(hi_i),
        .port0_pin_i(p0i), .port0_pin_o(p0o), .port0_pin_oe(p0oe),
        .port1_pin_i(p1i), .port1_pin_o(p1o), .port1_pin_oe(p1oe));
    pgpio_pin_model pm0 (.pin_o(p0o), .pin_oe(p0oe), .ext_val(ext0), .pin_i(p0i));
    pgpio_pin_model pm1 (.pin_o(p1o), .pin_oe(p1oe), .ext_val(ext1), .pin_i(p1i));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic hung(input logic busy);
        if (busy) begin
            err_count++;
            $display("BAD handshake expected done seen timeout");
            complete_run();
        end
    endtask

    task automatic settle;
        repeat (8) @(posedge aclk);
    endtask

    // Address and data are offered together; each is dropped only at its own taking edge.
    task automatic wr(input logic [5:0] a, input logic [7:0] v, input logic [1:0] r);
        logic ap, dp, bp;
        wq.push_back(r);
        awaddr <= a;
        wdata <= {24'h0, v};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        ap = 1'b1;
        dp = 1'b1;
        bp = 1'b1;
        for (int n = 0; n < 50 && (ap || dp); n++) begin
            @(posedge aclk);
            if (ap && awready) begin awvalid <= 1'b0; ap = 1'b0; end
            if (dp && wready) begin wvalid <= 1'b0; dp = 1'b0; end
        end
        hung(ap || dp);
        for (int n = 0; n < 50 && bp; n++) begin
            @(posedge aclk);
            if (bvalid) bp = 1'b0;
        end
        hung(bp);
    endtask

    task automatic rd(input logic [5:0] a, input logic [1:0] r, input logic [31:0] e);
        logic ap, rp;
        rq.push_back({r, e});
        araddr <= a;
        arvalid <= 1'b1;
        ap = 1'b1;
        rp = 1'b1;
        for (int n = 0; n < 50 && ap; n++) begin
            @(posedge aclk);
            if (arready) begin arvalid <= 1'b0; ap = 1'b0; end
        end
        hung(ap);
        for (int n = 0; n < 50 && rp; n++) begin
            @(posedge aclk);
            if (rvalid) rp = 1'b0;
        end
        hung(rp);
    endtask

    // Responses are matched against the oldest note at the edge that takes them.
    always @(posedge aclk) begin
        if (aresetn && bvalid) begin
            if (wq.size() == 0) chk("unexpected bresp", 32'h0, 32'h1);
            else chk("bresp", {30'h0, wq.pop_front()}, {30'h0, bresp});
        end
        if (aresetn && rvalid) begin
            if (rq.size() == 0) chk("unexpected rdata", 32'h0, 32'h1);
            else begin
                rnote = rq.pop_front();
                chk("rresp", {30'h0, rnote[33:32]}, {30'h0, rresp});
                chk("rdata", rnote[31:0], rdata);
            end
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, arvalid, epm, eacc, drv, awaddr, araddr} = '0;
        {wdata, wstrb, lo_o, hi_o, mid_o, err_count, checks} = '0;
        rel_n = 1'b1;
        rnd = 8'h4f;
        ext0 = rnd;
        rnd = lfsr(rnd);
        ext1 = rnd;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("p0 oe", 32'h0, p0oe);
        chk("p1 oe", 32'h0, p1oe);
        rd(6'h04, pgpio_pkg::RESP_OKAY, {24'h0, ext1});
        rd(6'h14, pgpio_pkg::RESP_OKAY, 32'h0);
        rd(6'h1c, pgpio_pkg::RESP_SLVERR, 32'h0);
        wr(6'h3c, 8'hff, pgpio_pkg::RESP_SLVERR);
        $display("test reset done");
        rnd = lfsr(rnd);
        d = rnd;
        rnd = lfsr(rnd);
        l = rnd;
        wr(6'h00, l, pgpio_pkg::RESP_OKAY);
        wr(6'h08, d, pgpio_pkg::RESP_OKAY);
        settle();
        chk("p0 oe dir", {24'h0, d}, p0oe);
        chk("p0 out", {24'h0, l & d}, p0o & d);
        rd(6'h00, pgpio_pkg::RESP_OKAY, {24'h0, (l & d) | (ext0 & ~d)});
        $display("test port0 gpio done");
        eacc <= 1'b1;
        settle();
        chk("p0 oe bus idle", 32'h0, p0oe);
        chk("low bus in", {24'h0, ext0}, lo_i);
        rd(6'h20, pgpio_pkg::RESP_OKAY, 32'h1);
        rd(6'h08, pgpio_pkg::RESP_OKAY, 32'h0);
        rnd = lfsr(rnd);
        lo_o <= rnd;
        drv <= 1'b1;
        settle();
        chk("p0 oe bus", 32'hff, p0oe);
        chk("p0 bus out", {24'h0, rnd}, p0o);
        eacc <= 1'b0;
        drv <= 1'b0;
        settle();
        wr(6'h08, 8'h00, pgpio_pkg::RESP_OKAY);
        rd(6'h20, pgpio_pkg::RESP_OKAY, 32'h0);
        $display("test port0 bus done");
        rnd = lfsr(rnd);
        d = rnd;
        rnd = lfsr(rnd);
        f = rnd;
        rnd = lfsr(rnd);
        l = rnd;
        hi_o <= lfsr(rnd);
        mid_o <= ~rnd;
        wr(6'h04, l, pgpio_pkg::RESP_OKAY);
        wr(6'h10, d, pgpio_pkg::RESP_OKAY);
        wr(6'h14, f, pgpio_pkg::RESP_OKAY);
        drv <= 1'b1;
        settle();
        chk("p1 oe roles", {24'h0, f | d}, p1oe);
        chk("p1 out roles", {24'h0, (d & ~f & l) | (f & ~d & hi_o) | (f & d & mid_o)},
            p1o & p1oe);
        rel_n <= 1'b0;
        settle();
        chk("p1 oe released", {24'h0, d & ~f}, p1oe);
        chk("p1 out released", {24'h0, d & ~f & l}, p1o & p1oe);
        rd(6'h20, pgpio_pkg::RESP_OKAY, 32'h4);
        rd(6'h04, pgpio_pkg::RESP_OKAY, {24'h0, (d & ~f & l) | (ext1 & ~(d & ~f))});
        rel_n <= 1'b1;
        $display("test port1 roles done");
        epm <= 1'b1;
        settle();
        chk("p0 oe prog mem", 32'hff, p0oe);
        chk("p0 out prog mem", {24'h0, lo_o}, p0o);
        chk("p1 oe prog mem", 32'hff, p1oe);
        chk("p1 out prog mem", {24'h0, hi_o}, p1o);
        rel_n <= 1'b0;
        settle();
        chk("p0 oe prog released", 32'h0, p0oe);
        chk("p1 oe prog released", 32'h0, p1oe);
        rd(6'h20, pgpio_pkg::RESP_OKAY, 32'h6);
        $display("test program memory done");
        complete_run();
    end
endmodule // ports_zero_one_gpio_bus_mux_tb_top
`default_nettype wire
